// ==== inc/fsp_regs.svh ====
/*
  opcode, count and layout constants for the status/protect block.
  assumes: included by bare name wherever a constant is needed.
*/
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// instruction codes seen on the serial link
`define OPC_WR_ENABLE  8'h06
`define OPC_WR_DISABLE 8'h04
`define OPC_RD_LOW     8'h05
`define OPC_RD_HIGH    8'h35
`define OPC_WR_STATUS  8'h01
`define OPC_PAGE_PROG  8'h02
`define OPC_SECT_ERASE 8'h20
`define OPC_BLK_ERASE  8'hd8
`define OPC_SUSPEND    8'h75
`define OPC_RESUME     8'h7a

// byte counts (opcode included) that make a command whole, and the last bit index of a byte
`define NB_SINGLE   3'h1
`define NB_SR_ONE   3'h2
`define NB_SR_TWO   3'h3
`define NB_ADDR     3'h4
`define NB_PROG_MIN 3'h5
`define LAST_BIT    3'h7

// array geometry, counted in 4KB sectors
`define SECT_HI     21
`define SECT_LO     12
`define BLK_LO      16
`define NSECT       11'h400
`define BLK_FIRST   4'h0
`define BLK_LAST    4'hf

`endif

// ==== inc/fsp_pkg.sv ====
/*
  types of the status/protect block: register layouts, modes, pins.
  assumes: fsp_regs.svh holds the numeric constants.
*/
package fsp_pkg;

  // first status register, msb first
  typedef struct packed {
    logic status_guard_low;
    logic small_unit_protect;
    logic protect_origin_select;
    logic range_bit_two;
    logic range_bit_one;
    logic range_bit_zero;
    logic write_enable_latch;
    logic busy_flag;
  } fsp_sr1_s;

  // second status register, msb first
  typedef struct packed {
    logic paused_operation_flag;
    logic complement_map;
    logic otp_lock_three;
    logic otp_lock_two;
    logic otp_lock_one;
    logic reserved;
    logic quad_lines_enable;
    logic status_guard_high;
  } fsp_sr2_s;

  // synchronised link pins
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
    logic wp_n;
  } fsp_pins_s;

  // embedded operation state, gray along idle-run-paused
  typedef enum logic [1:0] {
    OP_IDLE  = 2'h0,
    OP_RUN   = 2'h1,
    OP_PAUSE = 2'h3
  } fsp_op_e;

  // status write guard mode {high, low}
  typedef enum logic [1:0] {
    SG_SOFT = 2'h0,
    SG_HW   = 2'h1,
    SG_LOCK = 2'h2,
    SG_OTP  = 2'h3
  } fsp_guard_e;

endpackage : fsp_pkg

// ==== design/fsp_sync.sv ====
/*
  two-flop synchroniser for a group of asynchronous levels.
  assumes: inputs are levels, readers tolerate two cycles of lag.
*/
`timescale 1ns/1ps
module fsp_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;  // first stage, read only by sync_out

  // plain two-stage capture; reset value idles the link (all high)
  always_ff @(posedge clk) begin
    if (reset) begin
      meta     <= '1;
      sync_out <= '1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : fsp_sync

// ==== design/fsp_top.sv ====
/*
  status/control register pair of a serial nor flash, with write guard,
  array protection check, embedded-operation timing and suspend.
  assumes: serial clock well below clk/4; reset is power-on (factory
  state); power_cycle is a one-cycle pulse from clk-domain logic.
*/
// How it works
// - busy bit high while an operation runs
// - write latch low refuses writes, programs, erases
// - protection bits change only by status write
// - protected area refuses program and erase
// - protection bits locked under hardware guard while the pin is low
// - unit bit picks 64KB blocks or 4KB sectors
// - origin bit picks top-down or bottom-up range
// - three range bits size it, zero none
// - complement bit inverts the protected area
// - quad bit turns guard pins into data
// - lock bits make security registers read-only
// - lock bits start clear, set once, stay
// - suspend instruction sets read-only paused flag
// - resume or power cycle clears paused flag
// - guard pair picks status write protection mode
// - high guard bit reinterprets the low one
// - defined status bits reset to zero
// - lock-down refuses writes until power cycle
// - hardware guard with pin low locks status
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_top
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES  = 1000,  // page program busy time
  parameter int ERASE_CYCLES = 4000,  // sector/block erase busy time
  parameter int WRSR_CYCLES  = 200    // status write busy time
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       power_cycle,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       si,
  input  wire logic       wp_n,
  output logic            so_out,
  output logic            so_oe_n,
  output logic            quad_lines_enable,
  output logic [2:0]      otp_locks,
  output logic            busy_flag
);
  fsp_pins_s   pin_q;          // synchronised pins
  logic        sclk_d;         // previous sclk level
  logic        cs_d;           // previous cs_n level
  logic [2:0]  bit_cnt;        // bits of current byte
  logic [2:0]  byte_cnt;       // whole bytes, saturating
  logic [7:0]  shift;          // incoming byte
  logic [7:0]  opcode;         // first byte of command
  logic [23:0] addr;           // address or data bytes
  fsp_sr1_s    sr1;            // first status register
  fsp_sr2_s    sr2;            // second status register
  fsp_op_e     op;             // embedded operation state
  logic        op_is_wrsr;     // running op cannot be suspended
  logic [31:0] op_cnt;         // cycles left in the operation
  logic        reading;        // status read in progress
  logic        rd_high;        // which register is read

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        whole;
  logic [7:0]  byte_in;
  logic        wp_ok;
  logic        sr_writable;
  fsp_guard_e  guard;
  logic        prog_hit;
  logic        erase_hit;
  fsp_sr1_s    next_sr1;
  fsp_sr2_s    next_sr2;
  logic [7:0]  rd_byte;

  // pins cross in through two flops before anything looks at them
  fsp_sync #(.WIDTH(4)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({cs_n, sclk, si, wp_n}),
    .sync_out (pin_q)
  );

  // protected test for one 4KB sector index
  function automatic logic prot_hit(input fsp_sr1_s s1,
                                    input logic cmp,
                                    input logic [9:0] sect);
    logic [2:0]  bp;
    logic [10:0] n;
    logic        hit;
    bp = {s1.range_bit_two, s1.range_bit_one, s1.range_bit_zero};
    // protected size in sectors; sector mode caps at half a block below all-ones, which protects all
    case (bp)
      3'h0:    n = 11'h000;
      3'h1:    n = s1.small_unit_protect ? 11'h001 : 11'h010;
      3'h2:    n = s1.small_unit_protect ? 11'h002 : 11'h020;
      3'h3:    n = s1.small_unit_protect ? 11'h004 : 11'h040;
      3'h4:    n = s1.small_unit_protect ? 11'h008 : 11'h080;
      3'h5:    n = s1.small_unit_protect ? 11'h008 : 11'h100;
      3'h6:    n = s1.small_unit_protect ? 11'h008 : 11'h200;
      default: n = `NSECT;
    endcase
    if (s1.protect_origin_select)
      hit = ({1'b0, sect} < n);
    else
      hit = ({1'b0, sect} >= (`NSECT - n));
    return hit ^ cmp;
  endfunction : prot_hit

  // edge finders on the synchronised link
  assign sclk_rise = pin_q.sclk & ~sclk_d;
  assign sclk_fall = ~pin_q.sclk & sclk_d;
  assign cs_rise   = pin_q.cs_n & ~cs_d;
  assign whole     = (bit_cnt == 3'h0);
  assign byte_in   = {shift[6:0], pin_q.si};

  // write guard: quad mode takes the pin away, so it reads high
  assign wp_ok = sr2.quad_lines_enable | pin_q.wp_n;
  assign guard = fsp_guard_e'({sr2.status_guard_high,
                               sr1.status_guard_low});
  always_comb begin
    case (guard)
      SG_SOFT: sr_writable = sr1.write_enable_latch;
      SG_HW:   sr_writable = sr1.write_enable_latch & wp_ok;
      default: sr_writable = 1'b0;
    endcase
  end

  // a block erase touches protection iff either end sector does
  assign prog_hit  = prot_hit(sr1, sr2.complement_map,
                              addr[`SECT_HI:`SECT_LO]);
  assign erase_hit = (opcode == `OPC_BLK_ERASE) ?
    (prot_hit(sr1, sr2.complement_map,
              {addr[`SECT_HI:`BLK_LO], `BLK_FIRST}) |
     prot_hit(sr1, sr2.complement_map,
              {addr[`SECT_HI:`BLK_LO], `BLK_LAST})) : prog_hit;

  // edge history of clock and select
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_d <= 1'b1;
      cs_d   <= 1'b1;
    end else begin
      sclk_d <= pin_q.sclk;
      cs_d   <= pin_q.cs_n;
    end
  end

  // byte assembly; deselect restarts framing
  always_ff @(posedge clk) begin
    if (reset || pin_q.cs_n) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      // page data beyond the address only needs counting
      if (bit_cnt == `LAST_BIT && byte_cnt != 3'h7)
        byte_cnt <= byte_cnt + 3'h1;
    end
  end

  // shift register, opcode and address capture
  always_ff @(posedge clk) begin
    if (reset) begin
      shift  <= 8'h00;
      opcode <= 8'h00;
      addr   <= 24'h000000;
    end else if (!pin_q.cs_n && sclk_rise) begin
      shift <= byte_in;
      if (bit_cnt == `LAST_BIT) begin
        if (byte_cnt == 3'h0)
          opcode <= byte_in;
        else if (byte_cnt < `NB_ADDR)
          addr <= {addr[15:0], byte_in};
      end
    end
  end

  // candidate values for a status write; busy and latch are not data
  always_comb begin
    next_sr1 = sr1;
    next_sr2 = sr2;
    if (byte_cnt == `NB_SR_TWO) begin
      next_sr1 = fsp_sr1_s'(addr[15:8]);
      next_sr2 = fsp_sr2_s'(addr[7:0]);
    end else begin
      next_sr1 = fsp_sr1_s'(addr[7:0]);
    end
    next_sr1.busy_flag          = 1'b1;
    next_sr1.write_enable_latch = 1'b0;
    // paused flag is read-only, reserved bit is dropped
    next_sr2.paused_operation_flag = sr2.paused_operation_flag;
    next_sr2.reserved              = 1'b0;
    // lock bits only ever gain ones
    next_sr2.otp_lock_three = next_sr2.otp_lock_three |
                              sr2.otp_lock_three;
    next_sr2.otp_lock_two   = next_sr2.otp_lock_two | sr2.otp_lock_two;
    next_sr2.otp_lock_one   = next_sr2.otp_lock_one | sr2.otp_lock_one;
  end

  // status registers and the embedded operation, one owner for both
  always_ff @(posedge clk) begin
    if (reset) begin
      sr1        <= '0;
      sr2        <= '0;
      op         <= OP_IDLE;
      op_is_wrsr <= 1'b0;
      op_cnt     <= 32'h0;
    end else if (power_cycle) begin
      // supply loss aborts work; volatile bits and lock-down clear
      sr1.busy_flag              <= 1'b0;
      sr1.write_enable_latch     <= 1'b0;
      sr2.paused_operation_flag  <= 1'b0;
      if (guard == SG_LOCK)
        sr2.status_guard_high    <= 1'b0;
      op     <= OP_IDLE;
      op_cnt <= 32'h0;
    end else begin
      // countdown of the running operation
      if (op == OP_RUN) begin
        if (op_cnt <= 32'h1) begin
          op            <= OP_IDLE;
          sr1.busy_flag <= 1'b0;
        end else begin
          op_cnt <= op_cnt - 32'h1;
        end
      end
      // commands act on deselect, and only when byte-aligned
      if (cs_rise && whole) begin
        case (opcode)
          `OPC_WR_ENABLE: begin
            if (op == OP_IDLE && byte_cnt == `NB_SINGLE)
              sr1.write_enable_latch <= 1'b1;
          end
          `OPC_WR_DISABLE: begin
            if (op == OP_IDLE && byte_cnt == `NB_SINGLE)
              sr1.write_enable_latch <= 1'b0;
          end
          `OPC_WR_STATUS: begin
            // guard and latch together decide; refusal leaves all
            if (op == OP_IDLE && sr_writable &&
                (byte_cnt == `NB_SR_ONE ||
                 byte_cnt == `NB_SR_TWO)) begin
              sr1        <= next_sr1;
              sr2        <= next_sr2;
              op         <= OP_RUN;
              op_is_wrsr <= 1'b1;
              op_cnt     <= 32'(WRSR_CYCLES);
            end
          end
          `OPC_PAGE_PROG: begin
            if (op == OP_IDLE && sr1.write_enable_latch &&
                byte_cnt >= `NB_PROG_MIN && !prog_hit) begin
              sr1.busy_flag          <= 1'b1;
              sr1.write_enable_latch <= 1'b0;
              op         <= OP_RUN;
              op_is_wrsr <= 1'b0;
              op_cnt     <= 32'(PROG_CYCLES);
            end
          end
          `OPC_SECT_ERASE, `OPC_BLK_ERASE: begin
            if (op == OP_IDLE && sr1.write_enable_latch &&
                byte_cnt == `NB_ADDR && !erase_hit) begin
              sr1.busy_flag          <= 1'b1;
              sr1.write_enable_latch <= 1'b0;
              op         <= OP_RUN;
              op_is_wrsr <= 1'b0;
              op_cnt     <= 32'(ERASE_CYCLES);
            end
          end
          `OPC_SUSPEND: begin
            // a status write is too short to be worth pausing
            if (op == OP_RUN && !op_is_wrsr &&
                byte_cnt == `NB_SINGLE) begin
              op                        <= OP_PAUSE;
              sr1.busy_flag             <= 1'b0;
              sr2.paused_operation_flag <= 1'b1;
            end
          end
          `OPC_RESUME: begin
            if (op == OP_PAUSE && byte_cnt == `NB_SINGLE) begin
              op                        <= OP_RUN;
              sr1.busy_flag             <= 1'b1;
              sr2.paused_operation_flag <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // live register image for reads; reserved bit forced low
  always_comb begin
    rd_byte = rd_high ? 8'(sr2) : 8'(sr1);
    if (rd_high)
      rd_byte[2] = 1'b0;
  end

  // read mode opens after the opcode byte of a status read
  always_ff @(posedge clk) begin
    if (reset || pin_q.cs_n) begin
      reading <= 1'b0;
      rd_high <= 1'b0;
    end else if (sclk_rise && bit_cnt == `LAST_BIT &&
                 byte_cnt == 3'h0) begin
      reading <= (byte_in == `OPC_RD_LOW) ||
                 (byte_in == `OPC_RD_HIGH);
      rd_high <= (byte_in == `OPC_RD_HIGH);
    end
  end

  // serial out on falling edges; value tracks busy live each byte
  always_ff @(posedge clk) begin
    if (reset || pin_q.cs_n) begin
      so_out  <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (reading && sclk_fall) begin
      so_out  <= rd_byte[3'h7 - bit_cnt];
      so_oe_n <= 1'b0;
    end
  end

  // side outputs, registered copies of state
  always_ff @(posedge clk) begin
    if (reset) begin
      quad_lines_enable <= 1'b0;
      otp_locks         <= 3'h0;
      busy_flag         <= 1'b0;
    end else begin
      quad_lines_enable <= sr2.quad_lines_enable;
      otp_locks         <= {sr2.otp_lock_three, sr2.otp_lock_two,
                            sr2.otp_lock_one};
      busy_flag         <= sr1.busy_flag;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic wrsr_go;
  assign wrsr_go = cs_rise && whole && opcode == `OPC_WR_STATUS &&
                   op == OP_IDLE && !power_cycle;

  a_busy_tracks: assert property (
    sr1.busy_flag == (op == OP_RUN))
    else $error("busy bit disagrees with operation state");
  a_wel_refuse: assert property (
    wrsr_go && !sr1.write_enable_latch |=> $stable(sr1[7:2]))
    else $error("status written without write latch");
  a_prot_refuse: assert property (
    cs_rise && whole && opcode == `OPC_PAGE_PROG && prog_hit &&
    op == OP_IDLE && !power_cycle |=> op == OP_IDLE)
    else $error("program started in protected area");
  a_hw_guard: assert property (
    wrsr_go && guard == SG_HW && !wp_ok
    |=> $stable(sr1[7:2]) && $stable(sr2))
    else $error("status written with guard pin low");
  a_lockdown_hold: assert property (
    wrsr_go && guard == SG_LOCK |=> $stable(sr2) ##1 $stable(sr2))
    else $error("status written under lock-down");
  a_pcyc_unlock: assert property (
    power_cycle && guard == SG_LOCK |=> guard == SG_SOFT)
    else $error("power cycle kept lock-down");
  a_otp_sticky: assert property (
    sr2.otp_lock_one |=> sr2.otp_lock_one [*8])
    else $error("lock bit returned to zero");
  a_pause_set: assert property (
    op == OP_RUN ##1 op == OP_PAUSE
    |-> sr2.paused_operation_flag && !sr1.busy_flag)
    else $error("suspend did not set paused flag");
  a_pause_clr: assert property (
    op == OP_PAUSE && !power_cycle ##1 op == OP_RUN
    |-> !sr2.paused_operation_flag)
    else $error("resume left paused flag set");
  a_rsvd_zero: assert property (
    !sr2.reserved)
    else $error("reserved bit set");
  a_wrsr_busy: assert property (
    $rose(op_is_wrsr) |-> sr1.busy_flag && op == OP_RUN)
    else $error("status write not busy");

  c_status_write: cover property (
    wrsr_go && sr_writable ##1 op == OP_RUN);
  c_suspend: cover property (op == OP_RUN ##1 op == OP_PAUSE);
  c_read_high: cover property (reading && rd_high && !so_oe_n);
endmodule : fsp_top

// ==== bench/fsp_host.sv ====
/*
  host side of the serial link: frames commands msb first in mode 0.
  assumes: the bench sequences calls; 64 ns serial clock period.
*/
`timescale 1ns/1ps
module fsp_host (
  output logic      cs_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe_n
);
  // idle link: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // one framed command of n bytes; rd keeps the last byte seen on so
  task automatic xfer(input int n, input logic [39:0] d,
                      output logic [7:0] rd);
    rd = 8'h00;
    #32 cs_n = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      si = d[39-i];
      #32 sclk = 1'b1;
      // sample half a period after the fall, well past its settling
      // undriven line reads inverted, so a late enable shows as bad data
      rd = {rd[6:0], so_oe_n ? ~so_out : so_out};
      #32 sclk = 1'b0;
    end
    #32 cs_n = 1'b1;
    // released line shows no stale bit
    si = ~si;
    // gap lets the synced deselect act before the next frame
    #64;
  endtask : xfer
endmodule : fsp_host

// ==== bench/fsp_top_tb_top.sv ====
/*
  self-checking bench: status/protect registers driven over the link.
  assumes: fsp_host frames commands; reset is power-on factory state.
*/
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_top_tb_top
  import fsp_pkg::*;
;
  logic       clk, reset, power_cycle, cs_n, sclk, si, wp_n;
  logic       so_out, so_oe_n, quad_lines_enable, busy_flag;
  logic [2:0] otp_locks;
  logic [7:0] rd;             // last read byte
  int         num_errors = 0; // mismatches
  int         checks = 0;     // comparisons made

  // program long enough that reads and suspend land inside it
  fsp_top #(.PROG_CYCLES(600), .ERASE_CYCLES(30), .WRSR_CYCLES(20))
    fsp_top_i (.clk(clk), .reset(reset), .power_cycle(power_cycle),
    .cs_n(cs_n), .sclk(sclk), .si(si), .wp_n(wp_n), .so_out(so_out),
    .so_oe_n(so_oe_n), .quad_lines_enable(quad_lines_enable),
    .otp_locks(otp_locks), .busy_flag(busy_flag));
  fsp_host fsp_host_i (.cs_n(cs_n), .sclk(sclk), .si(si),
    .so_out(so_out), .so_oe_n(so_oe_n));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic final_report();
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input int n, input logic [39:0] d);
    fsp_host_i.xfer(n, d, rd);
  endtask : op

  // read one register and compare
  task automatic rdreg(input logic [7:0] opc, input logic [7:0] exp);
    fsp_host_i.xfer(2, {opc, 32'h0}, rd);
    chk(rd, exp);
  endtask : rdreg

  // bounded wait for the busy port to drop; a hang ends the run
  task automatic idle();
    for (int i = 0; i < 1000 && busy_flag !== 1'b0; i++) @(negedge clk);
    if (busy_flag !== 1'b0) begin
      num_errors++;
      $display("BAD %0t busy never cleared", $time);
      final_report();
    end
  endtask : idle

  // latch set before every write, as the host must
  task automatic wrsr(input logic [7:0] a, input logic [7:0] b);
    op(1, {`OPC_WR_ENABLE, 32'h0});
    op(3, {`OPC_WR_STATUS, a, b, 16'h0});
    idle();
  endtask : wrsr

  task automatic prog(input logic [23:0] addr);
    op(1, {`OPC_WR_ENABLE, 32'h0});
    op(5, {`OPC_PAGE_PROG, addr, 8'ha5});
  endtask : prog

  // erase with latch set; exp says whether it may start
  task automatic erase(input logic [7:0]  opc,
                       input logic [23:0] a,
                       input logic        exp);
    op(1, {`OPC_WR_ENABLE, 32'h0});
    op(4, {opc, a, 8'h00});
    chk({7'h0, busy_flag}, {7'h0, exp});
    idle();
  endtask : erase

  task automatic pcycle();
    @(negedge clk) power_cycle = 1'b1;
    @(negedge clk) power_cycle = 1'b0;
    repeat (4) @(negedge clk);
  endtask : pcycle

  // protection cases: reg1, reg2, address, program accepted
  logic [40:0] ptab [8] = '{
    {8'h04, 8'h38, 24'h3f0000, 1'b0}, {8'h04, 8'h38, 24'h3e0000, 1'b1},
    {8'h24, 8'h38, 24'h000000, 1'b0}, {8'h44, 8'h38, 24'h3ff000, 1'b0},
    {8'h44, 8'h38, 24'h3fe000, 1'b1}, {8'h04, 8'h78, 24'h000000, 1'b0},
    {8'h04, 8'h78, 24'h3f0000, 1'b1}, {8'h00, 8'h38, 24'h000000, 1'b1}};

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    power_cycle = 1'b0;
    wp_n = 1'b1;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    // factory state
    chk({4'h0, otp_locks, quad_lines_enable}, 8'h00);
    rdreg(`OPC_RD_LOW, 8'h00);
    rdreg(`OPC_RD_HIGH, 8'h00);
    // write without the latch is ignored
    op(3, {`OPC_WR_STATUS, 8'h04, 8'h3e, 16'h0});
    rdreg(`OPC_RD_LOW, 8'h00);
    op(5, {`OPC_PAGE_PROG, 24'h0, 8'h00});
    chk({7'h0, busy_flag}, 8'h00);
    op(1, {`OPC_WR_ENABLE, 32'h0});
    rdreg(`OPC_RD_LOW, 8'h02);
    // wp_n is driven by the bench, never tied, so quad may be set
    op(3, {`OPC_WR_STATUS, 8'h00, 8'h3e, 16'h0});
    chk({7'h0, busy_flag}, 8'h01);
    idle();
    rdreg(`OPC_RD_HIGH, 8'h3a);
    chk({4'h0, otp_locks, quad_lines_enable}, 8'h0f);
    wrsr(8'h00, 8'h00);
    rdreg(`OPC_RD_HIGH, 8'h38);
    // array protection table
    foreach (ptab[k]) begin
      wrsr(ptab[k][40:33], ptab[k][32:25]);
      prog(ptab[k][24:1]);
      chk({7'h0, busy_flag}, {7'h0, ptab[k][0]});
      idle();
    end
    // disable command drops the latch again
    op(1, {`OPC_WR_ENABLE, 32'h0});
    op(1, {`OPC_WR_DISABLE, 32'h0});
    rdreg(`OPC_RD_LOW, 8'h00);
    // erases against a protected top sector
    wrsr(8'h44, 8'h38);
    erase(`OPC_SECT_ERASE, 24'h3ff000, 1'b0);
    erase(`OPC_BLK_ERASE, 24'h3f0000, 1'b0);
    erase(`OPC_SECT_ERASE, 24'h3f0000, 1'b1);
    erase(`OPC_BLK_ERASE, 24'h3e0000, 1'b1);
    // one-byte status write touches only the first register
    op(1, {`OPC_WR_ENABLE, 32'h0});
    op(2, {`OPC_WR_STATUS, 8'h00, 24'h0});
    idle();
    rdreg(`OPC_RD_LOW, 8'h00);
    rdreg(`OPC_RD_HIGH, 8'h38);
    // suspend and resume in mid-program
    wrsr(8'h00, 8'h38);
    prog(24'h000000);
    rdreg(`OPC_RD_LOW, 8'h01);
    op(1, {`OPC_SUSPEND, 32'h0});
    rdreg(`OPC_RD_HIGH, 8'hb8);
    op(1, {`OPC_RESUME, 32'h0});
    rdreg(`OPC_RD_HIGH, 8'h38);
    idle();
    prog(24'h000000);
    op(1, {`OPC_SUSPEND, 32'h0});
    pcycle();
    rdreg(`OPC_RD_HIGH, 8'h38);
    rdreg(`OPC_RD_LOW, 8'h00);
    // hardware guard with the pin low, then high
    wrsr(8'h80, 8'h38);
    @(negedge clk) wp_n = 1'b0;
    wrsr(8'h84, 8'h38);
    rdreg(`OPC_RD_LOW, 8'h82);
    @(negedge clk) wp_n = 1'b1;
    wrsr(8'h84, 8'h38);
    rdreg(`OPC_RD_LOW, 8'h84);
    // quad mode frees the guard pin
    wrsr(8'h80, 8'h3a);
    @(negedge clk) wp_n = 1'b0;
    wrsr(8'h84, 8'h3a);
    rdreg(`OPC_RD_LOW, 8'h84);
    @(negedge clk) wp_n = 1'b1;
    // lock-down until a supply cycle
    wrsr(8'h00, 8'h39);
    wrsr(8'h04, 8'h38);
    rdreg(`OPC_RD_HIGH, 8'h39);
    pcycle();
    rdreg(`OPC_RD_HIGH, 8'h38);
    // one-time protection survives a supply cycle
    wrsr(8'h80, 8'h39);
    pcycle();
    wrsr(8'h04, 8'h38);
    rdreg(`OPC_RD_HIGH, 8'h39);
    // refused write leaves the latch that was set for it
    rdreg(`OPC_RD_LOW, 8'h82);
    final_report();
  end
endmodule : fsp_top_tb_top
